/* File: common/ncd_pkg.sv */
// package: register map, opcode fields, clock-count figures and carriers
package ncd_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_IPTR_OFS   = 8'h08;
  localparam logic [7:0] REG_OPTR_OFS   = 8'h0c;
  localparam logic [7:0] REG_INSTR_OFS  = 8'h10;
  localparam logic [7:0] REG_CLEAR_OFS  = 8'h14;

  // control register fields
  localparam int CTRL_DMASK_BIT = 1;
  localparam int CTRL_PMASK_BIT = 5;
  localparam int CTRL_PROT_BIT  = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_003f;

  // status register fields
  localparam int ST_DFLAG_BIT   = 1;
  localparam int ST_PFLAG_BIT   = 5;
  localparam int ST_SUMMARY_BIT = 7;
  localparam int ST_BUSY_BIT    = 8;
  localparam int ST_CC_LSB      = 9;
  localparam int ST_OP_LSB      = 13;

  // escape recognition
  localparam logic [4:0] ESCAPE_PATTERN = 5'h1b;
  localparam logic [1:0] AMODE_REG      = 2'h3;
  localparam logic [2:0] REG_LOAD       = 3'h0;
  localparam logic [2:0] REG_STORE      = 3'h2;
  localparam logic [2:0] REG_STPOP      = 3'h3;
  localparam logic [2:0] REG_LI_LD      = 3'h5;
  localparam logic [2:0] REG_LI_STP     = 3'h7;
  localparam logic [2:0] OPF_LONG       = 3'h7;
  localparam logic [2:0] OPF_TEMP       = 3'h3;
  localparam logic [2:0] OPF_CPP        = 3'h6;
  localparam logic [2:0] OPF_XAM        = 3'h1;
  localparam logic [7:0] BYTE2_CPP      = 8'hd9;
  localparam logic [7:0] BYTE2_XAM      = 8'he5;
  localparam logic [1:0] FMT_REAL64     = 2'h2;
  localparam logic [1:0] FMT_INT16      = 2'h3;

  // clock counts used (upper figure of each range)
  localparam logic [7:0] CLK_LD_R64  = 8'd60;
  localparam logic [7:0] CLK_LD_I16  = 8'd54;
  localparam logic [7:0] CLK_LD_I64  = 8'd68;
  localparam logic [7:0] CLK_LD_T80  = 8'd65;
  localparam logic [7:0] CLK_ST_R64  = 8'd104;
  localparam logic [7:0] CLK_STP_R64 = 8'd106;
  localparam logic [7:0] CLK_STP_I64 = 8'd105;
  localparam logic [7:0] CLK_CP_R64  = 8'd77;
  localparam logic [7:0] CLK_CP_I16  = 8'd88;
  localparam logic [7:0] CLK_CPP     = 8'd55;
  localparam logic [7:0] CLK_XAM     = 8'd23;
  localparam logic [7:0] CLK_OTHER   = 8'd40;

  typedef enum logic [3:0] {
    OP_NONE, OP_LOAD, OP_LOAD_I64, OP_LOAD_T80, OP_STORE, OP_STPOP,
    OP_STPOP_I64, OP_CMPPOP, OP_CMPPOP2, OP_EXAMINE, OP_OTHER
  } ncd_op_e;

  typedef struct packed {
    ncd_op_e    op;
    logic [7:0] clocks;
    logic [1:0] pops;
  } ncd_dec_s;

  // one instruction handed in by the host side
  typedef struct packed {
    logic [7:0]  byte1;
    logic [7:0]  byte2;
    logic [31:0] prefix_addr;
    logic [31:0] mem_addr;
    logic        exp_min;
    logic        sig_nonzero;
    logic        inexact;
    logic [3:0]  class_cc;
  } ncd_instr_s;

endpackage : ncd_pkg

/* File: rtl/ncd_decode.sv */
// opcode decoder: escape check, instruction class, clock count, pops
`timescale 1ns/10ps
`default_nettype none
module ncd_decode
(
  // opcode bytes
  input  wire logic [7:0]       byte1_i,
  input  wire logic [7:0]       byte2_i,
  // result
  output logic                  is_escape_o,
  output ncd_pkg::ncd_dec_s     dec_o
);

  logic [2:0] opf;
  logic [1:0] fmt;
  logic [1:0] amode;
  logic [2:0] rfield;

  assign is_escape_o = (byte1_i[7:3] == ncd_pkg::ESCAPE_PATTERN);
  assign opf         = byte1_i[2:0];
  assign fmt         = opf[2:1];
  assign amode    = byte2_i[7:6];
  assign rfield   = byte2_i[5:3];

  always_comb
  begin
    dec_o.op     = ncd_pkg::OP_OTHER;
    dec_o.clocks = ncd_pkg::CLK_OTHER;
    dec_o.pops   = 2'h0;
    if (!is_escape_o)
    begin
      dec_o.op = ncd_pkg::OP_NONE;
    end
    else if (opf == ncd_pkg::OPF_CPP && byte2_i == ncd_pkg::BYTE2_CPP)
    begin
      dec_o.op     = ncd_pkg::OP_CMPPOP2;
      dec_o.clocks = ncd_pkg::CLK_CPP;
      dec_o.pops   = 2'h2;
    end
    else if (opf == ncd_pkg::OPF_XAM && byte2_i == ncd_pkg::BYTE2_XAM)
    begin
      dec_o.op     = ncd_pkg::OP_EXAMINE;
      dec_o.clocks = ncd_pkg::CLK_XAM;
    end
    else if (amode != ncd_pkg::AMODE_REG)
    begin
      if (opf == ncd_pkg::OPF_LONG && rfield == ncd_pkg::REG_LI_LD)
      begin
        dec_o.op     = ncd_pkg::OP_LOAD_I64;
        dec_o.clocks = ncd_pkg::CLK_LD_I64;
      end
      else if (opf == ncd_pkg::OPF_LONG && rfield == ncd_pkg::REG_LI_STP)
      begin
        dec_o.op     = ncd_pkg::OP_STPOP_I64;
        dec_o.clocks = ncd_pkg::CLK_STP_I64;
        dec_o.pops   = 2'h1;
      end
      else if (opf == ncd_pkg::OPF_TEMP && rfield == ncd_pkg::REG_LI_LD)
      begin
        dec_o.op     = ncd_pkg::OP_LOAD_T80;
        dec_o.clocks = ncd_pkg::CLK_LD_T80;
      end
      else if (opf[0] && rfield == ncd_pkg::REG_LOAD)
      begin
        dec_o.op     = ncd_pkg::OP_LOAD;
        dec_o.clocks = (fmt == ncd_pkg::FMT_INT16) ? ncd_pkg::CLK_LD_I16
                                                 : ncd_pkg::CLK_LD_R64;
      end
      else if (opf[0] && rfield == ncd_pkg::REG_STORE)
      begin
        dec_o.op     = ncd_pkg::OP_STORE;
        dec_o.clocks = ncd_pkg::CLK_ST_R64;
      end
      else if (opf[0] && rfield == ncd_pkg::REG_STPOP)
      begin
        dec_o.op     = ncd_pkg::OP_STPOP;
        dec_o.clocks = ncd_pkg::CLK_STP_R64;
        dec_o.pops   = 2'h1;
      end
      else if (!opf[0] && rfield == ncd_pkg::REG_STPOP)
      begin
        dec_o.op     = ncd_pkg::OP_CMPPOP;
        dec_o.clocks = (fmt == ncd_pkg::FMT_INT16) ? ncd_pkg::CLK_CP_I16
                                                 : ncd_pkg::CLK_CP_R64;
        dec_o.pops   = 2'h1;
      end
    end
  end

endmodule // ncd_decode
`default_nettype wire

/* File: rtl/ncd_top.sv */
// numeric coprocessor decode and fault reporting with apb registers
//
// Overview of operation
// - masked denormal: instruction runs on normally
// - denormal when exponent minimal and significand nonzero
// - inexact result rounded and inexact flag set
// - masked inexact: only the flag is set
// - unmasked fault sets flag, summary bit and fault output
// - fault records instruction and lowest operand address
// - instruction address points at first prefix byte
// - protected mode keeps no opcode, only the two pointers
// - load decoded; 60 clocks real64, 54 clocks int16
// - long integer load decoded, 68 clocks
// - temporary real load decoded, 65 clocks
// - store decoded, 104 clocks real64
// - store and pop decoded, one pop, 106 clocks
// - long integer store and pop decoded, 105 clocks
// - compare and pop decoded; 77 real64, 88 int16
// - compare pop twice decoded, two pops, 55 clocks
// - examine decoded, class into condition code, 23 clocks
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ncd_top
(
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                reset_n_i,
  // apb slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic [31:0]              prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // instruction from host
  input  wire logic                instr_valid_i,
  input  wire ncd_pkg::ncd_instr_s instr_i,
  output logic                     busy_o,
  // toward host
  output logic                     fault_o,
  output logic [1:0]               pops_o
);

  ncd_pkg::ncd_dec_s dec;
  logic              is_escape;
  logic [31:0]       ctrl_q;
  logic [7:0]        flags_q;
  logic [3:0]        cc_q;
  ncd_pkg::ncd_op_e  op_q;
  logic [7:0]        cnt_q;
  logic [1:0]        pend_pops_q;
  logic [31:0]       iptr_q;
  logic [31:0]       optr_q;
  logic [15:0]       opc_q;
  logic              start;
  logic              denorm;
  logic              den_unm;
  logic              inx_unm;
  logic              done;
  logic              wr_en;
  logic              rd_en;
  logic              clr_en;

  ncd_decode u_dec
  (
    .byte1_i     (instr_i.byte1),
    .byte2_i     (instr_i.byte2),
    .is_escape_o (is_escape),
    .dec_o       (dec)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_en  = psel_i && penable_i && pwrite_i;
  assign rd_en  = psel_i && !penable_i && !pwrite_i;
  assign clr_en = wr_en && hit(paddr_i, ncd_pkg::REG_CLEAR_OFS);
  assign start  = instr_valid_i && is_escape && !busy_o;
  assign done   = busy_o && (cnt_q == 8'h01);

  assign denorm  = start && instr_i.exp_min && instr_i.sig_nonzero;
  assign den_unm = denorm && !ctrl_q[ncd_pkg::CTRL_DMASK_BIT];
  assign inx_unm = start && instr_i.inexact && !ctrl_q[ncd_pkg::CTRL_PMASK_BIT];

  // control register
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ctrl_q <= ncd_pkg::CTRL_RESET;
    else if (wr_en && hit(paddr_i, ncd_pkg::REG_CTRL_OFS))
      ctrl_q <= pwdata_i;
  end

  // execution timer
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      busy_o      <= 1'b0;
      cnt_q       <= 8'h00;
      op_q        <= ncd_pkg::OP_NONE;
      pend_pops_q <= 2'h0;
    end
    else if (start)
    begin
      busy_o      <= 1'b1;
      cnt_q       <= dec.clocks;
      op_q        <= dec.op;
      pend_pops_q <= dec.pops;
    end
    else if (done)
    begin
      busy_o <= 1'b0;
      cnt_q  <= 8'h00;
    end
    else if (busy_o)
      cnt_q <= cnt_q - 8'h01;
  end

  // pops reported when the instruction ends
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pops_o <= 2'h0;
    else
      pops_o <= done ? pend_pops_q : 2'h0;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      cc_q <= 4'h0;
    else if (start && dec.op == ncd_pkg::OP_EXAMINE)
      cc_q <= instr_i.class_cc;
  end

  // sticky flags, set wins over clear
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      flags_q <= 8'h00;
    else
    begin
      flags_q <= clr_en ? (flags_q & ~pwdata_i[7:0]) : flags_q;
      if (denorm)
        flags_q[ncd_pkg::ST_DFLAG_BIT] <= 1'b1;
      if (start && instr_i.inexact)
        flags_q[ncd_pkg::ST_PFLAG_BIT] <= 1'b1;
      if (den_unm || inx_unm)
        flags_q[ncd_pkg::ST_SUMMARY_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      fault_o <= 1'b0;
    else
      fault_o <= (den_unm || inx_unm) ||
                 (flags_q[ncd_pkg::ST_SUMMARY_BIT] &&
                  !(clr_en && pwdata_i[ncd_pkg::ST_SUMMARY_BIT]));
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      iptr_q <= 32'h0000_0000;
      optr_q <= 32'h0000_0000;
      opc_q  <= 16'h0000;
    end
    else if (den_unm || inx_unm)
    begin
      iptr_q <= instr_i.prefix_addr;
      optr_q <= instr_i.mem_addr;
      // opcode not kept in protected mode
      opc_q  <= ctrl_q[ncd_pkg::CTRL_PROT_BIT] ? 16'h0000
                                                : {instr_i.byte1, instr_i.byte2};
    end
  end

  // apb read and ready; one wait-free access phase
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      if (rd_en)
      begin
        unique case (paddr_i)
          ncd_pkg::REG_CTRL_OFS:   prdata_o <= ctrl_q;
          ncd_pkg::REG_STATUS_OFS: prdata_o <= {15'h0000, op_q, cc_q,
                                                busy_o, flags_q};
          ncd_pkg::REG_IPTR_OFS:   prdata_o <= iptr_q;
          ncd_pkg::REG_OPTR_OFS:   prdata_o <= optr_q;
          ncd_pkg::REG_INSTR_OFS:  prdata_o <= {16'h0000, opc_q};
          ncd_pkg::REG_CLEAR_OFS:  prdata_o <= 32'h0000_0000;
          default:
          begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b1;
          end
        endcase
      end
      else if (psel_i && !penable_i)
        pslverr_o <= !(hit(paddr_i, ncd_pkg::REG_CTRL_OFS) ||
                       hit(paddr_i, ncd_pkg::REG_CLEAR_OFS));
    end
  end

  // unmasked fault drives the pin next cycle
  chk_fault_raise: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (den_unm || inx_unm) |=> fault_o && flags_q[ncd_pkg::ST_SUMMARY_BIT])
    else $error("unmasked fault did not raise output");
  chk_denorm_masked: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (denorm && ctrl_q[ncd_pkg::CTRL_DMASK_BIT] && !inx_unm && !fault_o)
    |=> !fault_o && busy_o)
    else $error("masked denormal disturbed execution");
  chk_denorm_flag: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    denorm |=> flags_q[ncd_pkg::ST_DFLAG_BIT])
    else $error("denormal flag not set");
  chk_inexact_flag: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (start && instr_i.inexact) |=> flags_q[ncd_pkg::ST_PFLAG_BIT])
    else $error("inexact flag not set");
  chk_inexact_quiet: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (start && instr_i.inexact && !inx_unm && !den_unm && !fault_o) |=> !fault_o)
    else $error("masked inexact raised fault");
  chk_fault_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (fault_o && !clr_en) |=> fault_o)
    else $error("fault dropped without clear");
  chk_ptr_capture: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (den_unm || inx_unm) |=> iptr_q == $past(instr_i.prefix_addr)
                             && optr_q == $past(instr_i.mem_addr))
    else $error("fault pointers not captured");
  chk_prot_opcode: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ((den_unm || inx_unm) && ctrl_q[ncd_pkg::CTRL_PROT_BIT]) |=> opc_q == 16'h0000)
    else $error("opcode kept in protected mode");
  chk_cpp_time: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (start && dec.op == ncd_pkg::OP_CMPPOP2) |=> busy_o [*8])
    else $error("compare pop twice ended early");
  chk_xam_time: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (start && dec.op == ncd_pkg::OP_EXAMINE) |-> ##23 busy_o ##1 !busy_o)
    else $error("examine time wrong");
  chk_ld64_time: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (start && dec.op == ncd_pkg::OP_LOAD_I64) |-> ##68 busy_o ##1 !busy_o)
    else $error("long integer load time wrong");

  cov_fault: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) den_unm);
  cov_examine: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    start && dec.op == ncd_pkg::OP_EXAMINE);
  cov_pop2: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) pops_o == 2'h2);
  cov_clear: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    fault_o && clr_en);

endmodule // ncd_top
`default_nettype wire

/* File: verification/ncd_host_model.sv */
// host side model: issues escape instructions and takes the fault line
`timescale 1ns/10ps
`default_nettype none
module ncd_host_model
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  // from the coprocessor
  input  wire logic              busy_i,
  input  wire logic              fault_i,
  // toward the coprocessor
  output var ncd_pkg::ncd_instr_s instr_o,
  output logic                   instr_valid_o,
  // last exception vector taken
  output logic [7:0]             vector_o
);
  logic        task_switched_bit = 1'b0;
  logic        emulate_bit       = 1'b0;
  logic [31:0] seg_limit         = 32'h0000_ffff;
  int          issue_gap         = 0;
  logic        fault_q;

  initial
  begin
    instr_o       = '0;
    instr_valid_o = 1'b0;
    vector_o      = 8'h00;
  end

  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      fault_q <= 1'b0;
    else
    begin
      fault_q <= fault_i;
      if (fault_i && !fault_q)
        vector_o <= 8'h10;
    end
  end

  // escape or wait; operand taken as four words
  task automatic issue(input ncd_pkg::ncd_instr_s ins, input logic is_wait);
    int n;
    n = 0;
    while (busy_i !== 1'b0 && n < 400)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    if (task_switched_bit || (emulate_bit && !is_wait))
      vector_o <= 8'h07;
    else if (fault_i)
      vector_o <= 8'h07;
    else if (ins.mem_addr > seg_limit)
      vector_o <= 8'h0d;
    else if (ins.mem_addr + 32'h0000_0007 > seg_limit)
      vector_o <= 8'h09;
    else if (!is_wait)
    begin
      repeat (issue_gap) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      instr_o       <= ins;
      instr_valid_o <= 1'b1;
      @(posedge ref_clk_i);
      instr_valid_o <= 1'b0;
      instr_o       <= ncd_pkg::ncd_instr_s'(~ins);
    end
  endtask
endmodule // ncd_host_model
`default_nettype wire

/* File: verification/ncd_top_tb.sv */
// bench: decode timing, pops, fault flags, pointers and register map
`timescale 1ns/10ps
`default_nettype none
module ncd_top_tb;
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [2:0] ev;
    logic [7:0] clk;
    logic [1:0] pops;
    logic [7:0] flags;
  } ncd_row_s;

  // ev: exponent minimal, significand nonzero, inexact
  localparam logic [36:0] ROWS [13] = '{
    {8'hdd, 8'h06, 3'h6, 8'h3c, 2'h0, 8'h02},
    {8'hdf, 8'h06, 3'h4, 8'h36, 2'h0, 8'h00},
    {8'hdf, 8'h2e, 3'h2, 8'h44, 2'h0, 8'h00},
    {8'hdb, 8'h2e, 3'h1, 8'h41, 2'h0, 8'h20},
    {8'hdd, 8'h16, 3'h0, 8'h68, 2'h0, 8'h00},
    {8'hdd, 8'h1e, 3'h0, 8'h6a, 2'h1, 8'h00},
    {8'hdf, 8'h3e, 3'h7, 8'h69, 2'h1, 8'h22},
    {8'hdc, 8'h1e, 3'h0, 8'h4d, 2'h1, 8'h00},
    {8'hde, 8'h1e, 3'h0, 8'h58, 2'h1, 8'h00},
    {8'hde, 8'hd9, 3'h0, 8'h37, 2'h2, 8'h00},
    {8'h9b, 8'h06, 3'h0, 8'h00, 2'h0, 8'h00},
    {8'hd8, 8'h06, 3'h0, 8'h28, 2'h0, 8'h00},
    {8'hd9, 8'he5, 3'h0, 8'h17, 2'h0, 8'h00}
  };

  logic                ref_clk_i = 1'b0;
  logic                reset_n_i = 1'b0;
  logic                psel_i    = 1'b0;
  logic                penable_i = 1'b0;
  logic                pwrite_i  = 1'b0;
  logic [7:0]          paddr_i   = 8'h00;
  logic [31:0]         pwdata_i  = 32'h0000_0000;
  logic [31:0]         prdata_o;
  logic [31:0]         rdata;
  logic                pready_o;
  logic                pslverr_o;
  logic                rerr;
  logic                instr_valid_i;
  logic                busy_o;
  logic                fault_o;
  logic [1:0]          pops_o;
  logic [7:0]          host_vector;
  ncd_pkg::ncd_instr_s instr_i;
  int                  n_fail = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;

  ncd_top i_ncd_top
  (
    .ref_clk_i     (ref_clk_i),
    .reset_n_i     (reset_n_i),
    .psel_i        (psel_i),
    .penable_i     (penable_i),
    .pwrite_i      (pwrite_i),
    .paddr_i       (paddr_i),
    .pwdata_i      (pwdata_i),
    .prdata_o      (prdata_o),
    .pready_o      (pready_o),
    .pslverr_o     (pslverr_o),
    .instr_valid_i (instr_valid_i),
    .instr_i       (instr_i),
    .busy_o        (busy_o),
    .fault_o       (fault_o),
    .pops_o        (pops_o)
  );

  ncd_host_model i_ncd_host_model
  (
    .ref_clk_i     (ref_clk_i),
    .reset_n_i     (reset_n_i),
    .busy_i        (busy_o),
    .fault_i       (fault_o),
    .instr_o       (instr_i),
    .instr_valid_o (instr_valid_i),
    .vector_o      (host_vector)
  );

  always #50 ref_clk_i = ~ref_clk_i;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_fail++;
      $display("[ERR] %0t run too long", $time);
      complete_run();
    end
  end

  task automatic chk_port(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t port %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t register %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
    end
    while (pready_o !== 1'b1);
    chk_port({7'h0, pready_o}, 8'h01);
    rdata = prdata_o;
    rerr  = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(rdata & m, e);
  endtask

  // busy cycles counted; pops sampled in the cycle after busy
  task automatic run_instr(input ncd_pkg::ncd_instr_s ins, output int n);
    n = 0;
    i_ncd_host_model.issue(ins, 1'b0);
    #1;
    while (busy_o === 1'b1 && n < 300)
    begin
      n++;
      @(posedge ref_clk_i);
      #1;
    end
  endtask

  initial
  begin
    ncd_row_s            r;
    ncd_pkg::ncd_instr_s ins;
    int                  n;
    ins             = '0;
    ins.prefix_addr = 32'h0000_1000;
    ins.class_cc    = 4'ha;
    ins.byte1       = 8'hdd;
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    reg_chk(ncd_pkg::REG_CTRL_OFS, 32'hffff_ffff, 32'h0000_003f);
    chk_port({4'h0, pops_o, busy_o, fault_o}, 8'h00);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk_port({7'h0, rerr}, 8'h01);
    apb(1'b1, ncd_pkg::REG_STATUS_OFS, 32'hffff_ffff);
    chk_port({7'h0, rerr}, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      i_ncd_host_model.task_switched_bit = (k == 0);
      i_ncd_host_model.emulate_bit       = (k == 3);
      ins.mem_addr = (k == 1) ? 32'h0001_0000 : 32'h0000_fffe;
      run_instr(ins, n);
      chk_port(n[7:0], 8'h00);
      chk_port(host_vector, (k == 0 || k == 3) ? 8'h07 : ((k == 1) ? 8'h0d : 8'h09));
    end
    i_ncd_host_model.emulate_bit = 1'b0;
    ins.mem_addr = 32'h0000_0204;
    for (int i = 0; i < 13; i++)
    begin
      r = ROWS[i];
      ins.byte1 = r.b1;
      ins.byte2 = r.b2;
      {ins.exp_min, ins.sig_nonzero, ins.inexact} = r.ev;
      i_ncd_host_model.issue_gap = i % 3;
      run_instr(ins, n);
      chk_port(n[7:0], r.clk);
      chk_port({6'h0, pops_o}, {6'h0, r.pops});
      chk_port({7'h0, fault_o}, 8'h00);
      reg_chk(ncd_pkg::REG_STATUS_OFS, 32'h0000_00ff, {24'h0, r.flags});
      apb(1'b1, ncd_pkg::REG_CLEAR_OFS, 32'h0000_00ff);
    end
    reg_chk(ncd_pkg::REG_STATUS_OFS, 32'h0000_1e00, 32'h0000_1400);
    apb(1'b1, ncd_pkg::REG_CTRL_OFS, 32'h0000_003d);
    ins.byte1 = 8'hdd;
    ins.byte2 = 8'h06;
    {ins.exp_min, ins.sig_nonzero, ins.inexact} = 3'h6;
    run_instr(ins, n);
    chk_port({7'h0, fault_o}, 8'h01);
    chk_port(host_vector, 8'h10);
    reg_chk(ncd_pkg::REG_STATUS_OFS, 32'h0000_00ff, 32'h0000_0082);
    reg_chk(ncd_pkg::REG_IPTR_OFS, 32'hffff_ffff, 32'h0000_1000);
    reg_chk(ncd_pkg::REG_OPTR_OFS, 32'hffff_ffff, 32'h0000_0204);
    run_instr(ins, n);
    chk_port(host_vector, 8'h07);
    apb(1'b1, ncd_pkg::REG_CLEAR_OFS, 32'h0000_0002);
    chk_port({7'h0, fault_o}, 8'h01);
    apb(1'b1, ncd_pkg::REG_CLEAR_OFS, 32'h0000_0080);
    n = 0;
    while (fault_o !== 1'b0 && n < 3)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk_port({7'h0, fault_o}, 8'h00);
    apb(1'b1, ncd_pkg::REG_CTRL_OFS, 32'h0001_001f);
    ins.byte2 = 8'h16;
    {ins.exp_min, ins.sig_nonzero, ins.inexact} = 3'h1;
    run_instr(ins, n);
    chk_port({7'h0, fault_o}, 8'h01);
    reg_chk(ncd_pkg::REG_STATUS_OFS, 32'h0000_00ff, 32'h0000_00a0);
    reg_chk(ncd_pkg::REG_INSTR_OFS, 32'hffff_ffff, 32'h0000_0000);
    reg_chk(ncd_pkg::REG_IPTR_OFS, 32'hffff_ffff, 32'h0000_1000);
    // reset in mid-run with a fault pending
    reset_n_i <= 1'b0;
    @(posedge ref_clk_i);
    chk_port({4'h0, pops_o, busy_o, fault_o}, 8'h00);
    reset_n_i <= 1'b1;
    reg_chk(ncd_pkg::REG_CTRL_OFS, 32'hffff_ffff, 32'h0000_003f);
    reg_chk(ncd_pkg::REG_STATUS_OFS, 32'h0000_00ff, 32'h0000_0000);
    chk_port({7'h0, fault_o}, 8'h00);
    complete_run();
  end
endmodule // ncd_top_tb
`default_nettype wire
